/* File: lan_diag_pkg.sv */
// Constants shared by the FIFO diagnostic and controller status logic
package lan_diag_pkg;

   // ****************************************
   // Register decode
   // ****************************************
   localparam logic [2:0] DIAG_WINDOW = 3'h4;
   localparam logic [3:0] FIFO_DIAGNOSTIC_OFFSET = 4'h4;
   localparam logic [3:0] MAC_CORE_STATUS_OFFSET = 4'h8;

   // ****************************************
   // Field positions of fifo_diagnostic
   // ****************************************
   localparam int RX_PACKET_ACTIVE_BIT = 15;
   localparam int RX_READ_UNDERRUN_BIT = 13;
   localparam int RX_STATUS_FULL_BIT = 12;
   localparam int RX_FIFO_FULL_BIT = 11;
   localparam int TX_FIFO_OVERFLOW_BIT = 10;
   localparam int RX_SELFTEST_ENABLE_BIT = 7;
   localparam int RX_SELFTEST_FORCE_FAIL_BIT = 6;
   localparam int RX_SELFTEST_FAILED_BIT = 5;
   localparam int RX_SELFTEST_DONE_BIT = 4;
   localparam int TX_SELFTEST_ENABLE_BIT = 3;
   localparam int TX_SELFTEST_FORCE_FAIL_BIT = 2;
   localparam int TX_SELFTEST_FAILED_BIT = 1;
   localparam int TX_SELFTEST_DONE_BIT = 0;

   // ****************************************
   // Field positions of mac_core_status
   // ****************************************
   localparam int MAC_TX_STATUS_LSB = 8;
   localparam int MAC_RX_STATUS_LSB = 1;
   localparam int RX_TEST_ENABLE_BIT = 0;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [15:0] FIFO_DIAGNOSTIC_RESET = 16'h0000;
   localparam logic RX_TEST_ENABLE_RESET = 1'b0;

   // ****************************************
   // Receive FIFO limits and timing
   // ****************************************
   localparam int RX_PACKET_LIMIT = 8;
   localparam int RX_FIFO_BYTES = 2048;
   localparam int RX_FULL_RELEASE_BYTES = 4;
   localparam int CLK_KHZ = 25000;
   localparam int SELFTEST_TIME_MS = 500;
   localparam int SELFTEST_CYCLES = SELFTEST_TIME_MS * CLK_KHZ;

endpackage

/* File: fifo_ram_selftest.sv */
// Built-in self-test sequencer with its own RAM under test
`timescale 1ns/1ns
module fifo_ram_selftest #(
   parameter int DEPTH = 64,
   parameter int WIDTH = 8,
   parameter int RUN_CYCLES = lan_diag_pkg::SELFTEST_CYCLES
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic enable_in,
   input wire logic force_fail_in,
   output logic done_out,
   output logic failed_out
);
   initial begin
      if (DEPTH < 2 || WIDTH < 1 || RUN_CYCLES < 3 * DEPTH + 1) begin
         $error("fifo_ram_selftest: unusable parameters");
      end
   end

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_FILL = 6'b000010,
      ST_CHK0 = 6'b000100,
      ST_CHK1 = 6'b001000,
      ST_WAIT = 6'b010000,
      ST_DONE = 6'b100000
   } bist_state_type;

   bist_state_type state_q;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [$clog2(DEPTH)-1:0] addr_q;
   logic [31:0] cycles_q;
   logic last_addr;
   logic [WIDTH-1:0] rd_data;
   logic enable_prev_q;

   assign last_addr = (addr_q == ($clog2(DEPTH))'(DEPTH - 1));
   assign rd_data = mem[addr_q];

   // ****************************************
   // March: write zeros, check and flip, check ones
   // ****************************************
   always_ff @(posedge clk_in) begin
      unique case (state_q)
         ST_FILL: mem[addr_q] <= '0;
         ST_CHK0: mem[addr_q] <= '1;
         ST_CHK1: mem[addr_q] <= '0;
         default: ;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in || !enable_in) begin
         state_q <= ST_IDLE;
         addr_q <= '0;
         cycles_q <= '0;
      end else begin
         cycles_q <= (state_q == ST_IDLE) ? 32'h0000_0000 : cycles_q + 32'h0000_0001;
         unique case (state_q)
            ST_IDLE: state_q <= ST_FILL;
            ST_FILL, ST_CHK0, ST_CHK1: begin
               addr_q <= last_addr ? '0 : addr_q + 1'b1;
               if (last_addr) begin
                  state_q <= (state_q == ST_FILL) ? ST_CHK0 :
                             (state_q == ST_CHK0) ? ST_CHK1 : ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (cycles_q >= 32'(RUN_CYCLES - 1)) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: state_q <= ST_DONE;
         endcase
      end
   end

   // ****************************************
   // Result flags
   // ****************************************
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || !enable_in) begin
         done_out <= 1'b0;
      end else begin
         done_out <= (state_q == ST_DONE);
      end
   end

   // Only reset or the fall of enable clears fail, so a forced fail sticks
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         enable_prev_q <= 1'b0;
      end else begin
         enable_prev_q <= enable_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         failed_out <= 1'b0;
      end else if (force_fail_in) begin
         failed_out <= 1'b1;
      end else if (enable_prev_q && !enable_in) begin
         failed_out <= 1'b0;
      end else if ((state_q == ST_CHK0 && rd_data != '0) ||
                   (state_q == ST_CHK1 && rd_data != '1)) begin
         failed_out <= 1'b1;
      end
   end
endmodule

/* File: rx_fifo_monitor.sv */
// Receive FIFO occupancy and packet count watcher
`timescale 1ns/1ns
module rx_fifo_monitor #(
   parameter int FIFO_BYTES = lan_diag_pkg::RX_FIFO_BYTES,
   parameter int PACKET_LIMIT = lan_diag_pkg::RX_PACKET_LIMIT,
   parameter int RELEASE_BYTES = lan_diag_pkg::RX_FULL_RELEASE_BYTES
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic flush_in,
   input wire logic byte_wr_in,
   input wire logic byte_rd_in,
   input wire logic pkt_end_in,
   input wire logic pkt_pop_in,
   output logic status_full_out,
   output logic fifo_full_out
);
   initial begin
      if (PACKET_LIMIT < 1 || RELEASE_BYTES < 1 || RELEASE_BYTES >= FIFO_BYTES) begin
         $error("rx_fifo_monitor: unusable parameters");
      end
   end

   localparam int BW = $clog2(FIFO_BYTES + 1);
   localparam int PW = $clog2(PACKET_LIMIT + 1);

   logic [BW-1:0] bytes_q;
   logic [PW-1:0] pkts_q;
   logic wr_ok;
   logic rd_ok;

   assign wr_ok = byte_wr_in && (bytes_q != BW'(FIFO_BYTES));
   assign rd_ok = byte_rd_in && (bytes_q != '0);

   always_ff @(posedge clk_in) begin
      if (!reset_n_in || flush_in) begin
         bytes_q <= '0;
      end else if (wr_ok && !rd_ok) begin
         bytes_q <= bytes_q + 1'b1;
      end else if (rd_ok && !wr_ok) begin
         bytes_q <= bytes_q - 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in || flush_in) begin
         pkts_q <= '0;
      end else if (pkt_end_in && !pkt_pop_in && pkts_q != PW'(PACKET_LIMIT)) begin
         pkts_q <= pkts_q + 1'b1;
      end else if (pkt_pop_in && !pkt_end_in && pkts_q != '0) begin
         pkts_q <= pkts_q - 1'b1;
      end
   end

   // Full holds until a few bytes are drained
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || flush_in) begin
         fifo_full_out <= 1'b0;
      end else if (bytes_q == BW'(FIFO_BYTES)) begin
         fifo_full_out <= 1'b1;
      end else if (bytes_q <= BW'(FIFO_BYTES - RELEASE_BYTES)) begin
         fifo_full_out <= 1'b0;
      end
   end

   assign status_full_out = (pkts_q == PW'(PACKET_LIMIT));
endmodule

/* File: fifo_diag_and_mac_status.sv */
// FIFO diagnostic and controller status registers of the adapter
//
// Contract
// - Bit 15 shows packet entering receive FIFO
// - Receive underrun sets bit 13, holds, alarms
// - Underrun only on reads past packet end
// - Bit 12 set at eight held packets
// - Bit 11 set when receive FIFO full
// - Transmit overrun sets bit 10, stops transmitter
// - Receive and transmit self-tests run independently
// - Bits 7 and 3 start self-tests
// - Bits 6 and 2 force fail flags
// - Bits 5 and 1 report test failure
// - Bits 4 and 0 report test completion
// - Read-only diagnostic bits clear at reset
// - Status bits 15..8 mirror transmit indications
// - Status bits 7..1 mirror receive indications
// - Status bit 0 read/write, resets zero
// - Diagnostic register at offset 04, window 4
// - Controller status at offset 08, window 4
`timescale 1ns/1ns
module fifo_diag_and_mac_status #(
   parameter int RX_RAM_DEPTH = 64,
   parameter int TX_RAM_DEPTH = 64,
   parameter int RAM_WIDTH = 8,
   parameter int SELFTEST_CYCLES = lan_diag_pkg::SELFTEST_CYCLES,
   parameter int RX_FIFO_BYTES = lan_diag_pkg::RX_FIFO_BYTES,
   parameter int RX_PACKET_LIMIT = lan_diag_pkg::RX_PACKET_LIMIT
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Card I/O port
   input wire logic [2:0] window_in,
   input wire logic [3:0] io_addr_in,
   input wire logic io_rd_in,
   input wire logic io_wr_in,
   input wire logic [15:0] io_wdata_in,
   output logic [15:0] io_rdata_out,
   // Command pulses
   input wire logic rx_reset_cmd_in,
   input wire logic tx_reset_cmd_in,
   input wire logic global_reset_cmd_in,
   // Receive FIFO datapath
   input wire logic rx_pkt_start_in,
   input wire logic rx_byte_wr_in,
   input wire logic rx_pkt_end_in,
   input wire logic rx_byte_rd_in,
   input wire logic rx_pkt_pop_in,
   input wire logic rx_head_complete_in,
   input wire logic rx_head_empty_in,
   output logic rx_accept_out,
   // Transmit FIFO datapath
   input wire logic tx_byte_wr_in,
   input wire logic tx_fifo_at_limit_in,
   output logic tx_enable_out,
   // Controller raw status lines
   input wire logic [7:0] mac_tx_status_in,
   input wire logic [6:0] mac_rx_status_in,
   output logic rx_test_enable_out,
   // Failure alarm toward the interrupt logic
   output logic adapter_failure_out
);
   initial begin
      if (RAM_WIDTH < 1 || RAM_WIDTH > 16 || RX_PACKET_LIMIT < 1) begin
         $error("fifo_diag_and_mac_status: unusable parameters");
      end
      if (RX_RAM_DEPTH < 2 || TX_RAM_DEPTH < 2) begin
         $error("fifo_diag_and_mac_status: self-test RAM too shallow");
      end
      if (SELFTEST_CYCLES <= 3 * RX_RAM_DEPTH || SELFTEST_CYCLES <= 3 * TX_RAM_DEPTH) begin
         $error("fifo_diag_and_mac_status: self-test time too short");
      end
      if (RX_FIFO_BYTES <= lan_diag_pkg::RX_FULL_RELEASE_BYTES) begin
         $error("fifo_diag_and_mac_status: receive FIFO too small");
      end
   end

   // ****************************************
   // Address decode
   // ****************************************
   logic in_window;
   logic sel_diag;
   logic sel_status;
   logic wr_diag;
   logic wr_status;

   assign in_window = (window_in == lan_diag_pkg::DIAG_WINDOW);
   assign sel_diag = in_window && (io_addr_in == lan_diag_pkg::FIFO_DIAGNOSTIC_OFFSET);
   assign sel_status = in_window && (io_addr_in == lan_diag_pkg::MAC_CORE_STATUS_OFFSET);
   assign wr_diag = io_wr_in && sel_diag;
   assign wr_status = io_wr_in && sel_status;

   // ****************************************
   // Reset commands
   // ****************************************

   logic rx_flush;
   logic tx_flush;

   assign rx_flush = rx_reset_cmd_in || global_reset_cmd_in;
   assign tx_flush = tx_reset_cmd_in || global_reset_cmd_in;

   // ****************************************
   // Receive condition flags
   // ****************************************
   logic rx_packet_active_q;
   logic rx_read_underrun_q;
   logic rx_status_full;
   logic rx_fifo_full;
   logic rx_underrun_event;

   rx_fifo_monitor #(
      .FIFO_BYTES(RX_FIFO_BYTES),
      .PACKET_LIMIT(RX_PACKET_LIMIT),
      .RELEASE_BYTES(lan_diag_pkg::RX_FULL_RELEASE_BYTES)
   ) u_rx_monitor (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .flush_in(rx_flush),
      .byte_wr_in(rx_byte_wr_in),
      .byte_rd_in(rx_byte_rd_in),
      .pkt_end_in(rx_pkt_end_in),
      .pkt_pop_in(rx_pkt_pop_in),
      .status_full_out(rx_status_full),
      .fifo_full_out(rx_fifo_full)
   );

   // ****************************************
   // Packet acceptance and activity
   // ****************************************

   // New packets refused while either full flag stands
   assign rx_accept_out = !rx_status_full && !rx_fifo_full;

   always_ff @(posedge clk_in) begin
      if (!reset_n_in || rx_flush) begin
         rx_packet_active_q <= 1'b0;
      end else if (rx_pkt_start_in && rx_accept_out) begin
         rx_packet_active_q <= 1'b1;
      end else if (rx_pkt_end_in) begin
         rx_packet_active_q <= 1'b0;
      end
   end

   // ****************************************
   // Receive underrun
   // ****************************************

   // Reading an incomplete head packet gives bad data, no flag
   assign rx_underrun_event = rx_byte_rd_in && rx_head_complete_in && rx_head_empty_in;

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         rx_read_underrun_q <= 1'b0;
      end else if (rx_underrun_event) begin
         rx_read_underrun_q <= 1'b1;
      end else if (rx_flush) begin
         rx_read_underrun_q <= 1'b0;
      end
   end

   // ****************************************
   // Transmit overflow
   // ****************************************
   logic tx_fifo_overflow_q;
   logic tx_overflow_event;

   assign tx_overflow_event = tx_byte_wr_in && tx_fifo_at_limit_in;

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         tx_fifo_overflow_q <= 1'b0;
      end else if (tx_overflow_event) begin
         tx_fifo_overflow_q <= 1'b1;
      end else if (tx_flush) begin
         tx_fifo_overflow_q <= 1'b0;
      end
   end

   // ****************************************
   // Transmit enable and alarm
   // ****************************************

   assign tx_enable_out = !tx_fifo_overflow_q;
   assign adapter_failure_out = rx_read_underrun_q || tx_fifo_overflow_q;

   // ****************************************
   // Self-test control
   // ****************************************
   logic rx_selftest_enable_q;
   logic tx_selftest_enable_q;
   logic rx_force_pulse;
   logic tx_force_pulse;
   logic rx_selftest_done;
   logic rx_selftest_failed;
   logic tx_selftest_done;
   logic tx_selftest_failed;

   // Enables are held levels; writing zero stops and clears a test
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || global_reset_cmd_in) begin
         rx_selftest_enable_q <= 1'b0;
         tx_selftest_enable_q <= 1'b0;
      end else if (wr_diag) begin
         rx_selftest_enable_q <= io_wdata_in[lan_diag_pkg::RX_SELFTEST_ENABLE_BIT];
         tx_selftest_enable_q <= io_wdata_in[lan_diag_pkg::TX_SELFTEST_ENABLE_BIT];
      end
   end

   assign rx_force_pulse = wr_diag && io_wdata_in[lan_diag_pkg::RX_SELFTEST_FORCE_FAIL_BIT];
   assign tx_force_pulse = wr_diag && io_wdata_in[lan_diag_pkg::TX_SELFTEST_FORCE_FAIL_BIT];

   // ****************************************
   // Receive RAM self-test
   // ****************************************

   fifo_ram_selftest #(
      .DEPTH(RX_RAM_DEPTH),
      .WIDTH(RAM_WIDTH),
      .RUN_CYCLES(SELFTEST_CYCLES)
   ) u_rx_selftest (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .enable_in(rx_selftest_enable_q),
      .force_fail_in(rx_force_pulse),
      .done_out(rx_selftest_done),
      .failed_out(rx_selftest_failed)
   );

   // ****************************************
   // Transmit RAM self-test
   // ****************************************

   fifo_ram_selftest #(
      .DEPTH(TX_RAM_DEPTH),
      .WIDTH(RAM_WIDTH),
      .RUN_CYCLES(SELFTEST_CYCLES)
   ) u_tx_selftest (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .enable_in(tx_selftest_enable_q),
      .force_fail_in(tx_force_pulse),
      .done_out(tx_selftest_done),
      .failed_out(tx_selftest_failed)
   );

   // ****************************************
   // Controller status test bit
   // ****************************************
   logic rx_test_enable_q;

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         rx_test_enable_q <= lan_diag_pkg::RX_TEST_ENABLE_RESET;
      end else if (wr_status) begin
         rx_test_enable_q <= io_wdata_in[lan_diag_pkg::RX_TEST_ENABLE_BIT];
      end
   end

   assign rx_test_enable_out = rx_test_enable_q;

   // ****************************************
   // Read data
   // ****************************************
   logic [15:0] diag_view;
   logic [15:0] status_view;

   always_comb begin
      diag_view = lan_diag_pkg::FIFO_DIAGNOSTIC_RESET;
      diag_view[lan_diag_pkg::RX_PACKET_ACTIVE_BIT] = rx_packet_active_q;
      diag_view[lan_diag_pkg::RX_READ_UNDERRUN_BIT] = rx_read_underrun_q;
      diag_view[lan_diag_pkg::RX_STATUS_FULL_BIT] = rx_status_full;
      diag_view[lan_diag_pkg::RX_FIFO_FULL_BIT] = rx_fifo_full;
      diag_view[lan_diag_pkg::TX_FIFO_OVERFLOW_BIT] = tx_fifo_overflow_q;
      diag_view[lan_diag_pkg::RX_SELFTEST_FAILED_BIT] = rx_selftest_failed;
      diag_view[lan_diag_pkg::RX_SELFTEST_DONE_BIT] = rx_selftest_done;
      diag_view[lan_diag_pkg::TX_SELFTEST_FAILED_BIT] = tx_selftest_failed;
      diag_view[lan_diag_pkg::TX_SELFTEST_DONE_BIT] = tx_selftest_done;
   end

   // ****************************************
   // Controller status view
   // ****************************************

   always_comb begin
      status_view = 16'h0000;
      status_view[lan_diag_pkg::MAC_TX_STATUS_LSB +: 8] = mac_tx_status_in;
      status_view[lan_diag_pkg::MAC_RX_STATUS_LSB +: 7] = mac_rx_status_in;
      status_view[lan_diag_pkg::RX_TEST_ENABLE_BIT] = rx_test_enable_q;
   end

   // ****************************************
   // Register read port
   // ****************************************

   // Unmapped offsets and other windows read as zero
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         io_rdata_out <= 16'h0000;
      end else if (io_rd_in && sel_diag) begin
         io_rdata_out <= diag_view;
      end else if (io_rd_in && sel_status) begin
         io_rdata_out <= status_view;
      end else begin
         io_rdata_out <= 16'h0000;
      end
   end
endmodule

/* File: fifo_diag_chk.sv */
// Port assertions for the FIFO diagnostic and controller status block
`timescale 1ns/1ns
module fifo_diag_chk (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [2:0] window_in,
   input wire logic [3:0] io_addr_in,
   input wire logic io_rd_in,
   input wire logic io_wr_in,
   input wire logic [15:0] io_wdata_in,
   input wire logic [15:0] io_rdata_out,
   input wire logic rx_reset_cmd_in,
   input wire logic tx_reset_cmd_in,
   input wire logic global_reset_cmd_in,
   input wire logic rx_byte_rd_in,
   input wire logic rx_head_complete_in,
   input wire logic rx_head_empty_in,
   input wire logic tx_byte_wr_in,
   input wire logic tx_fifo_at_limit_in,
   input wire logic tx_enable_out,
   input wire logic [7:0] mac_tx_status_in,
   input wire logic [6:0] mac_rx_status_in,
   input wire logic rx_test_enable_out,
   input wire logic adapter_failure_out
);
   // ********
   // Checks
   // ********
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);
   property p_reset_state;
      $rose(reset_n_in) |-> io_rdata_out == 16'h0000 && tx_enable_out
         && !adapter_failure_out && !rx_test_enable_out;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
   property p_idle_rdata;
      !io_rd_in |=> io_rdata_out == 16'h0000;
   endproperty
   a_idle_rdata: assert property (p_idle_rdata) else $error("read data without read");
   property p_refused;
      io_rd_in && (window_in != 3'h4 || (io_addr_in != 4'h4 && io_addr_in != 4'h8))
         |=> io_rdata_out == 16'h0000;
   endproperty
   a_refused: assert property (p_refused) else $error("undecoded read answered");
   property p_mirror;
      io_rd_in && window_in == 3'h4 && io_addr_in == 4'h8 |=> io_rdata_out ==
         {$past(mac_tx_status_in), $past(mac_rx_status_in), $past(rx_test_enable_out)};
   endproperty
   a_mirror: assert property (p_mirror) else $error("status mirror wrong");
   property p_diag_zero;
      io_rd_in && window_in == 3'h4 && io_addr_in == 4'h4 |=> (io_rdata_out & 16'h43cc) == 0;
   endproperty
   a_diag_zero: assert property (p_diag_zero) else $error("write-only bit read");
   property p_testen;
      io_wr_in && window_in == 3'h4 && io_addr_in == 4'h8
         |=> rx_test_enable_out == $past(io_wdata_in[0]);
   endproperty
   a_testen: assert property (p_testen) else $error("test enable not written");
   property p_tx_over;
      tx_byte_wr_in && tx_fifo_at_limit_in |=> !tx_enable_out && adapter_failure_out;
   endproperty
   a_tx_over: assert property (p_tx_over) else $error("overflow not flagged");
   property p_tx_hold;
      !tx_enable_out && !tx_reset_cmd_in && !global_reset_cmd_in |=> !tx_enable_out;
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("transmitter resumed");
   property p_underrun;
      rx_byte_rd_in && rx_head_complete_in && rx_head_empty_in |=> adapter_failure_out;
   endproperty
   a_underrun: assert property (p_underrun) else $error("underrun not raised");
   property p_no_underrun;
      !adapter_failure_out && !rx_head_complete_in && !(tx_byte_wr_in && tx_fifo_at_limit_in)
         |=> !adapter_failure_out;
   endproperty
   a_no_underrun: assert property (p_no_underrun) else $error("false alarm");
   property p_alarm_hold;
      adapter_failure_out && !rx_reset_cmd_in && !tx_reset_cmd_in && !global_reset_cmd_in
         |=> adapter_failure_out;
   endproperty
   a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped");
endmodule
bind fifo_diag_and_mac_status fifo_diag_chk fifo_diag_chk_inst (.*);

/* File: fifo_diag_and_mac_status_test.sv */
// Self-checking bench for the FIFO diagnostic and controller status block
`timescale 1ns/1ns
module fifo_diag_and_mac_status_test;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [2:0] window_in = 3'h4;
   logic [3:0] io_addr_in = 4'h0;
   logic io_rd_in = 1'b0;
   logic io_wr_in = 1'b0;
   logic [15:0] io_wdata_in = 16'h0000;
   logic rx_head_complete_in = 1'b0;
   logic rx_head_empty_in = 1'b0;
   logic tx_fifo_at_limit_in = 1'b0;
   logic [7:0] mac_tx_status_in = 8'h00;
   logic [6:0] mac_rx_status_in = 7'h00;
   logic [8:0] pl = 9'h000;
   logic [15:0] io_rdata_out;
   logic rx_accept_out, tx_enable_out, rx_test_enable_out, adapter_failure_out;
   wire rx_reset_cmd_in, tx_reset_cmd_in, global_reset_cmd_in, rx_pkt_start_in;
   wire rx_byte_wr_in, rx_pkt_end_in, rx_byte_rd_in, rx_pkt_pop_in, tx_byte_wr_in;
   logic [15:0] rv;
   int failures = 0;
   int tests_run = 0;
   // Pulse lines packed for one-cycle strobes
   assign {rx_reset_cmd_in, tx_reset_cmd_in, global_reset_cmd_in, rx_pkt_start_in,
      rx_byte_wr_in, rx_pkt_end_in, rx_byte_rd_in, rx_pkt_pop_in, tx_byte_wr_in} = pl;
   fifo_diag_and_mac_status #(.RX_RAM_DEPTH(16), .TX_RAM_DEPTH(16), .SELFTEST_CYCLES(200),
      .RX_FIFO_BYTES(16)) fifo_diag_and_mac_status_inst (.*);
   initial begin
      forever #20 clk_in = ~clk_in;
   end
   // ********
   // Tasks
   // ********
   task automatic chk_reg(string n, logic [15:0] e, logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(string n, logic e, logic g);
      chk_reg(n, {15'h0000, e}, {15'h0000, g});
   endtask
   task automatic bus(logic w, logic [2:0] win, logic [3:0] a, logic [15:0] d);
      @(posedge clk_in);
      window_in <= win;
      io_addr_in <= a;
      io_wdata_in <= d;
      io_wr_in <= w;
      io_rd_in <= !w;
      @(posedge clk_in);
      io_wr_in <= 1'b0;
      io_rd_in <= 1'b0;
      #1;
      rv = io_rdata_out;
   endtask
   task automatic pulse(logic [8:0] m);
      @(posedge clk_in);
      pl <= m;
      @(posedge clk_in);
      pl <= 9'h000;
      #1;
   endtask
   task automatic poll(logic [15:0] m);
      for (int i = 0; i < 400; i++) begin
         bus(1'b0, 3'h4, 4'h4, 16'h0000);
         if ((rv & m) === m) break;
      end
      chk_reg("self-test done", m, rv & m);
   endtask
   task automatic give_verdict();
      if (failures == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      failures++;
      give_verdict();
   end
   // ********
   // Scenarios
   // ********
   initial begin
      logic [14:0] m;
      void'($urandom(32'hf365));
      repeat (3) @(posedge clk_in);
      reset_n_in <= 1'b1;
      {mac_tx_status_in, mac_rx_status_in} <= 15'h7fff;
      bus(1'b0, 3'h4, 4'h4, 16'h0000);
      chk_reg("diag after reset", 16'h0000, rv);
      bus(1'b1, 3'h3, 4'h8, 16'h0001);
      chk_bit("test enable other window", 1'b0, rx_test_enable_out);
      bus(1'b0, 3'h3, 4'h8, 16'h0000);
      chk_reg("status other window", 16'h0000, rv);
      bus(1'b0, 3'h4, 4'h6, 16'h0000);
      chk_reg("unmapped offset", 16'h0000, rv);
      for (int i = 0; i < 6; i++) begin
         m = 15'($urandom);
         @(posedge clk_in);
         {mac_tx_status_in, mac_rx_status_in} <= m;
         bus(1'b1, 3'h4, 4'h8, {15'h0000, m[0]});
         bus(1'b0, 3'h4, 4'h8, 16'h0000);
         chk_reg("controller status", {m, m[0]}, rv);
      end
      bus(1'b1, 3'h4, 4'h8, 16'h0000);
      bus(1'b1, 3'h4, 4'h4, 16'h0080);
      poll(16'h0010);
      chk_reg("rx test alone", 16'h0010, rv & 16'h0033);
      bus(1'b1, 3'h4, 4'h4, 16'h0088);
      poll(16'h0001);
      chk_reg("both tests", 16'h0011, rv & 16'h0033);
      bus(1'b1, 3'h4, 4'h4, 16'h00c8);
      bus(1'b1, 3'h4, 4'h4, 16'h0088);
      bus(1'b0, 3'h4, 4'h4, 16'h0000);
      chk_reg("forced rx fail", 16'h0031, rv & 16'h0033);
      bus(1'b1, 3'h4, 4'h4, 16'h0000);
      bus(1'b0, 3'h4, 4'h4, 16'h0000);
      chk_reg("tests cleared", 16'h0000, rv);
      bus(1'b1, 3'h4, 4'h4, 16'h0004);
      bus(1'b0, 3'h4, 4'h4, 16'h0000);
      chk_reg("forced tx fail", 16'h0002, rv);
      bus(1'b1, 3'h4, 4'h4, 16'h0008);
      bus(1'b1, 3'h4, 4'h4, 16'h0000);
      pulse(9'h020);
      pulse(9'h010);
      pulse(9'h010);
      bus(1'b0, 3'h4, 4'h4, 16'h0000);
      chk_reg("packet entering", 16'h8000, rv);
      pulse(9'h008);
      bus(1'b0, 3'h4, 4'h4, 16'h0000);
      chk_reg("packet written", 16'h0000, rv);
      @(posedge clk_in);
      rx_head_empty_in <= 1'b1;
      pulse(9'h004);
      chk_bit("read past received", 1'b0, adapter_failure_out);
      @(posedge clk_in);
      rx_head_complete_in <= 1'b1;
      pulse(9'h004);
      chk_bit("underrun alarm", 1'b1, adapter_failure_out);
      bus(1'b0, 3'h4, 4'h4, 16'h0000);
      chk_reg("underrun held", 16'h2000, rv);
      pulse(9'h100);
      chk_bit("alarm after rx reset", 1'b0, adapter_failure_out);
      @(posedge clk_in);
      rx_head_complete_in <= 1'b0;
      rx_head_empty_in <= 1'b0;
      pulse(9'h040);
      for (int i = 1; i <= 8; i++) begin
         pulse(9'h020);
         pulse(9'h008);
         chk_bit("accept below limit", i < 8, rx_accept_out);
      end
      pulse(9'h020);
      bus(1'b0, 3'h4, 4'h4, 16'h0000);
      chk_reg("status full", 16'h1000, rv);
      pulse(9'h002);
      bus(1'b0, 3'h4, 4'h4, 16'h0000);
      chk_reg("status full cleared", 16'h0000, rv);
      pulse(9'h040);
      for (int i = 0; i < 18; i++) begin
         pulse(9'h010);
      end
      chk_bit("accept when full", 1'b0, rx_accept_out);
      for (int i = 0; i < 3; i++) begin
         pulse(9'h004);
      end
      bus(1'b0, 3'h4, 4'h4, 16'h0000);
      chk_reg("fifo full", 16'h0800, rv);
      pulse(9'h004);
      bus(1'b0, 3'h4, 4'h4, 16'h0000);
      chk_reg("fifo full released", 16'h0000, rv);
      pulse(9'h001);
      chk_bit("tx below limit", 1'b1, tx_enable_out);
      @(posedge clk_in);
      tx_fifo_at_limit_in <= 1'b1;
      pulse(9'h001);
      chk_bit("tx overflow alarm", 1'b1, adapter_failure_out);
      @(posedge clk_in);
      tx_fifo_at_limit_in <= 1'b0;
      bus(1'b0, 3'h4, 4'h4, 16'h0000);
      chk_reg("tx overflow", 16'h0400, rv);
      pulse(9'h080);
      chk_bit("tx after reset cmd", 1'b1, tx_enable_out);
      bus(1'b1, 3'h4, 4'h8, 16'h0001);
      pulse(9'h020);
      @(posedge clk_in);
      reset_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      reset_n_in <= 1'b1;
      bus(1'b0, 3'h4, 4'h4, 16'h0000);
      chk_reg("diag after second reset", 16'h0000, rv);
      chk_bit("test enable after reset", 1'b0, rx_test_enable_out);
      give_verdict();
   end
endmodule
